// >>> egs_pkg.sv
// Constants, register map and encodings for the gas/climate measurement sequencer.
// Assumes one 50 MHz clock domain, with registers reached over AXI4-Lite with 32-bit data.
package egs_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_MODE = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_MEAS = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_GAS = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_WAIT_BASE = 12'h040;
    localparam logic [ADDR_W-1:0] OFS_HEAT_BASE = 12'h080;
    localparam logic [ADDR_W-1:0] OFS_FLD_BASE = 12'h100;
    localparam logic [ADDR_W-1:0] FLD_STRIDE = 12'h010;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int MEAS_T_LSB = 0;
    localparam int MEAS_P_LSB = 3;
    localparam int MEAS_H_LSB = 6;
    localparam int MEAS_IIR_BIT = 9;
    localparam int GAS_EN_BIT = 4;
    localparam int STEPS = 10;
    localparam int FIELDS = 3;
    localparam int QTY = 4;
    localparam int RES_W = 20;
    localparam logic [1:0] Q_T = 2'h0;
    localparam logic [1:0] Q_P = 2'h1;
    localparam logic [1:0] Q_H = 2'h2;
    localparam logic [1:0] Q_G = 2'h3;
    localparam int HUM_W = 16;
    localparam int BASE_W = 16;
    localparam int IIR_SHIFT = 2;
    localparam logic [2:0] OSR_MAX_CODE = 3'h5;
    localparam logic [4:0] GAS_TICKS = 5'h04;

    // ------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_FORCED = 2'h1;
    localparam logic [1:0] MODE_PARALLEL = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TPH = 3'b001,
        ST_HEAT = 3'b010,
        ST_GAS = 3'b011,
        ST_STORE = 3'b100
    } egs_state_type;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam int MS_NS = 1000000;

endpackage : egs_pkg

// >>> egs_sequencer.sv
// Mode controller and measurement sequencer with AXI4-Lite register access.
// Assumes a front end that converts on each rising edge of conv_tick and presents conv_data,
// both asynchronous to aclk; conv_data is held stable across the tick edge.
//
// Function
// RULE_01 - After reset the block sits in sleep mode, converting nothing.
// RULE_02 - Mode write during a measurement is held until that period ends.
// RULE_03 - While a mode change pends, further mode and control writes are dropped.
// RULE_04 - Mode code 00 sleeps, 01 single-shot, 10 continuous parallel.
// RULE_05 - Single-shot runs one full cycle then returns to sleep itself.
// RULE_06 - Parallel mode repeats cycles and never drops to sleep itself.
// RULE_07 - Single-shot converts T, P, H, gas in turn with one heater step.
// RULE_08 - Single-shot powers the heater only in the gas phase.
// RULE_09 - Parallel mode heats the plate while T, P, H convert.
// RULE_10 - Host enables at least one of T, P, H before parallel mode.
// RULE_11 - Ten heater steps stored and run as a self-repeating profile.
// RULE_12 - Oversampling codes 0 skip, 1 gives 1x, 2 gives 2x, 5 gives 16x.
// RULE_13 - Host writes humidity oversampling first, then T and P together.
// RULE_14 - Eight-bit duration and set-point registers for steps zero to nine.
// RULE_15 - Heater step select picks the single-shot step; 0 means step zero.
// RULE_16 - Gas heating and conversion run only with gas enable set.
// RULE_17 - Duration code 0x59 gives 100 ms of heating before gas sampling.
// RULE_18 - Host programs all control registers before writing the mode.
// RULE_19 - Parallel results fill three data fields in FIFO order.
// RULE_20 - Optional smoothing on temperature and pressure only.
// RULE_21 - Temperature width is 20 with filter, else 16 plus code minus one.
// RULE_22 - Each period has T, P, H conversions, heating and gas measurement.
// RULE_23 - Mode code 11 behaves as sleep.
// RULE_24 - Single-shot results land in field zero before returning to sleep.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module egs_sequencer
    import egs_pkg::*;
#(
    parameter int MS_CYCLES = MS_NS / CLK_NS
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Front end
    input wire logic conv_tick,
    input wire logic [RES_W-1:0] conv_data,
    output logic conv_active,
    output logic [1:0] conv_select,
    output logic heater_on,
    output logic [7:0] heater_setpoint
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        egs_state_type st;
        logic awrdy;
        logic wrdy;
        logic aw_ok;
        logic w_ok;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] mode;
        logic pend;
        logic [1:0] pend_mode;
        logic [2:0] osrs_t;
        logic [2:0] osrs_p;
        logic [2:0] osrs_h;
        logic iir_en;
        logic [3:0] step_sel;
        logic gas_en;
        logic [STEPS-1:0][7:0] gas_wait;
        logic [STEPS-1:0][7:0] res_heat;
        logic [FIELDS-1:0][QTY-1:0][RES_W-1:0] fld;
        logic [FIELDS-1:0] fld_new;
        logic [1:0] wr_ptr;
        logic [RES_W-1:0] filt_t;
        logic [RES_W-1:0] filt_p;
        logic filt_ok;
        logic [3:0] cur_step;
        logic [1:0] qty;
        logic [4:0] ticks;
        logic [QTY-1:0][RES_W-1:0] res;
        logic [31:0] pres;
        logic [11:0] ms_left;
        logic heat_run;
        logic heater_on;
        logic [7:0] heater_sp;
        logic conv_active;
        logic [1:0] conv_sel;
        logic [1:0] lk_sync;
        logic lk_prev;
        logic [RES_W-1:0] d_meta;
        logic [RES_W-1:0] d_sync;
    } egs_regs_type;

    egs_regs_type r_ff;
    egs_regs_type nxt_r;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Oversampling code to number of front-end ticks; codes above 16x saturate
    function automatic logic [4:0] osr_ticks(input logic [2:0] code);
        logic [2:0] c;
        c = (code > OSR_MAX_CODE) ? OSR_MAX_CODE : code;
        return 5'(5'h01 << (c - 3'h1));
    endfunction : osr_ticks

    // Keep only the significant bits of a left-aligned 20-bit result
    function automatic logic [RES_W-1:0] res_mask(input logic [2:0] code, input logic iir);
        logic [2:0] c;
        logic [4:0] drop;
        c = (code > OSR_MAX_CODE) ? OSR_MAX_CODE : code;
        drop = iir ? 5'h00 : 5'(RES_W - BASE_W) - 5'(c - 3'h1); // RULE_21
        return ~(20'(20'h0_0001 << drop) - 20'h0_0001);
    endfunction : res_mask

    // Duration code: low six bits in ms, top two bits scale by 1, 4, 16 or 64
    function automatic logic [11:0] heat_ms(input logic [7:0] code);
        return 12'(12'(code[5:0]) << {code[7:6], 1'b0}); // RULE_17
    endfunction : heat_ms

    // First-order smoothing toward the new sample
    function automatic logic [RES_W-1:0] smooth(input logic [RES_W-1:0] old, input logic [RES_W-1:0] cur);
        if (cur >= old) begin
            return old + ((cur - old) >> IIR_SHIFT);
        end
        return old - ((old - cur) >> IIR_SHIFT);
    endfunction : smooth

    // Register read decode: {error, data}
    function automatic logic [32:0] rd_word(input egs_regs_type s, input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        logic [32:0] v;
        v = {1'b1, 32'h0000_0000};
        if (a == OFS_MODE) begin
            v = {1'b0, 30'h0000_0000, s.mode};
        end else if (a == OFS_MEAS) begin
            v = {1'b0, 22'h00_0000, s.iir_en, s.osrs_h, s.osrs_p, s.osrs_t};
        end else if (a == OFS_GAS) begin
            v = {1'b0, 27'h000_0000, s.gas_en, s.step_sel};
        end else if (a == OFS_STATUS) begin
            v = {1'b0, 25'h000_0000, s.fld_new, s.wr_ptr, s.pend, s.st != ST_IDLE};
        end
        for (int i = 0; i < STEPS; i++) begin
            if (a == OFS_WAIT_BASE + ADDR_W'(4 * i)) begin
                v = {1'b0, 24'h00_0000, s.gas_wait[i]};
            end
            if (a == OFS_HEAT_BASE + ADDR_W'(4 * i)) begin
                v = {1'b0, 24'h00_0000, s.res_heat[i]};
            end
        end
        for (int f = 0; f < FIELDS; f++) begin
            for (int q = 0; q < QTY; q++) begin
                off = OFS_FLD_BASE + ADDR_W'(f * FLD_STRIDE) + ADDR_W'(4 * q);
                if (a == off) begin
                    v = {1'b0, 12'h000, s.fld[f][q]};
                end
            end
        end
        return v;
    endfunction : rd_word

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [32:0] rd;
        logic [31:0] wv;
        logic rise;
        logic busy;
        logic [4:0] need;
        logic tph_done;
        logic [3:0] sel;
        nxt_r = r_ff;
        rd = 33'h0_0000_0000;
        wv = 32'h0000_0000;
        tph_done = 1'b0;
        need = 5'h00;
        busy = (r_ff.st != ST_IDLE) || (r_ff.mode == MODE_FORCED) || (r_ff.mode == MODE_PARALLEL); // Period running or start due
        sel = (r_ff.step_sel > 4'(STEPS - 1)) ? 4'(STEPS - 1) : r_ff.step_sel;

        // Tick synchroniser; only the second stage feeds edge detection
        nxt_r.lk_sync = {r_ff.lk_sync[0], conv_tick};
        nxt_r.lk_prev = r_ff.lk_sync[1];
        nxt_r.d_meta = conv_data;
        nxt_r.d_sync = r_ff.d_meta;
        rise = r_ff.lk_sync[1] & ~r_ff.lk_prev;

        // Write channels are taken independently, in either order
        if (s_axi_awvalid && r_ff.awrdy) begin
            nxt_r.aw_ok = 1'b1;
            nxt_r.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r_ff.wrdy) begin
            nxt_r.w_ok = 1'b1;
            nxt_r.wdata = s_axi_wdata;
            nxt_r.wstrb = s_axi_wstrb;
        end
        if (r_ff.bvalid && s_axi_bready) begin
            nxt_r.bvalid = 1'b0;
        end
        if (r_ff.aw_ok && r_ff.w_ok && !r_ff.bvalid) begin
            rd = rd_word(r_ff, r_ff.awaddr);
            wv = rd[31:0];
            for (int b = 0; b < 4; b++) begin
                if (r_ff.wstrb[b]) begin
                    wv[8*b +: 8] = r_ff.wdata[8*b +: 8];
                end
            end
            nxt_r.aw_ok = 1'b0;
            nxt_r.w_ok = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
            // A pending change freezes every control register
            if (!r_ff.pend) begin // RULE_03
                if (r_ff.awaddr == OFS_MODE) begin
                    if (busy) begin
                        nxt_r.pend = 1'b1; // RULE_02
                        nxt_r.pend_mode = wv[1:0];
                    end else begin
                        nxt_r.mode = wv[1:0];
                        nxt_r.cur_step = 4'h0;
                        nxt_r.wr_ptr = 2'h0;
                    end
                end else if (r_ff.awaddr == OFS_MEAS) begin
                    nxt_r.osrs_t = wv[MEAS_T_LSB +: 3]; // RULE_12
                    nxt_r.osrs_p = wv[MEAS_P_LSB +: 3];
                    nxt_r.osrs_h = wv[MEAS_H_LSB +: 3];
                    nxt_r.iir_en = wv[MEAS_IIR_BIT];
                end else if (r_ff.awaddr == OFS_GAS) begin
                    nxt_r.step_sel = wv[3:0];
                    nxt_r.gas_en = wv[GAS_EN_BIT];
                end
                for (int i = 0; i < STEPS; i++) begin
                    if (r_ff.awaddr == OFS_WAIT_BASE + ADDR_W'(4 * i)) begin
                        nxt_r.gas_wait[i] = wv[7:0]; // RULE_14
                    end
                    if (r_ff.awaddr == OFS_HEAT_BASE + ADDR_W'(4 * i)) begin
                        nxt_r.res_heat[i] = wv[7:0]; // RULE_14
                    end
                end
            end
        end
        nxt_r.awrdy = !nxt_r.aw_ok && !nxt_r.bvalid;
        nxt_r.wrdy = !nxt_r.w_ok && !nxt_r.bvalid;

        // Read channel; reading a field's temperature word clears its new flag
        if (r_ff.rvalid && s_axi_rready) begin
            nxt_r.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r_ff.arrdy) begin
            rd = rd_word(r_ff, s_axi_araddr);
            nxt_r.rvalid = 1'b1;
            nxt_r.rdata = rd[31:0];
            nxt_r.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
            for (int f = 0; f < FIELDS; f++) begin
                if (s_axi_araddr == OFS_FLD_BASE + ADDR_W'(f * FLD_STRIDE)) begin
                    nxt_r.fld_new[f] = 1'b0;
                end
            end
        end
        nxt_r.arrdy = !nxt_r.rvalid;

        // Heater timer: counts whole milliseconds of hot-plate time
        if (r_ff.heat_run) begin
            if (r_ff.pres == 32'(MS_CYCLES - 1)) begin
                nxt_r.pres = 32'h0000_0000;
                nxt_r.ms_left = r_ff.ms_left - 12'h001;
                if (r_ff.ms_left == 12'h001) begin
                    nxt_r.heat_run = 1'b0;
                end
            end else begin
                nxt_r.pres = r_ff.pres + 32'h0000_0001;
            end
        end

        // Measurement sequencer
        case (r_ff.st)
            ST_IDLE: begin
                nxt_r.conv_active = 1'b0;
                nxt_r.heater_on = 1'b0;
                if (r_ff.pend) begin
                    // A change caught on the last cycle of a period lands here
                    nxt_r.mode = r_ff.pend_mode; // RULE_02
                    nxt_r.pend = 1'b0;
                    nxt_r.cur_step = 4'h0;
                    nxt_r.wr_ptr = 2'h0;
                end else if (r_ff.mode == MODE_FORCED || r_ff.mode == MODE_PARALLEL) begin // RULE_04 RULE_23
                    nxt_r.st = ST_TPH;
                    nxt_r.qty = Q_T;
                    nxt_r.ticks = 5'h00;
                    nxt_r.res = '0;
                    if (r_ff.mode == MODE_FORCED) begin
                        nxt_r.cur_step = sel; // RULE_15
                    end else if (r_ff.gas_en) begin
                        // Plate heats alongside the T, P, H conversions
                        nxt_r.heater_on = 1'b1; // RULE_09
                        nxt_r.heater_sp = r_ff.res_heat[r_ff.cur_step];
                        nxt_r.ms_left = heat_ms(r_ff.gas_wait[r_ff.cur_step]);
                        nxt_r.pres = 32'h0000_0000;
                        nxt_r.heat_run = (heat_ms(r_ff.gas_wait[r_ff.cur_step]) != 12'h000);
                    end
                end
            end
            ST_TPH: begin
                case (r_ff.qty)
                    Q_T: need = (r_ff.osrs_t == 3'h0) ? 5'h00 : osr_ticks(r_ff.osrs_t);
                    Q_P: need = (r_ff.osrs_p == 3'h0) ? 5'h00 : osr_ticks(r_ff.osrs_p);
                    default: need = (r_ff.osrs_h == 3'h0) ? 5'h00 : osr_ticks(r_ff.osrs_h);
                endcase
                nxt_r.conv_sel = r_ff.qty;
                nxt_r.conv_active = (need != 5'h00);
                // Zero oversampling skips the conversion in a single cycle
                if (need == 5'h00) begin // RULE_12
                    nxt_r.qty = r_ff.qty + 2'h1;
                    tph_done = (r_ff.qty == Q_H);
                end else if (rise) begin
                    nxt_r.ticks = r_ff.ticks + 5'h01;
                    if (r_ff.ticks == need - 5'h01) begin
                        case (r_ff.qty)
                            Q_T: nxt_r.res[Q_T] = r_ff.d_sync & res_mask(r_ff.osrs_t, r_ff.iir_en); // RULE_21
                            Q_P: nxt_r.res[Q_P] = r_ff.d_sync & res_mask(r_ff.osrs_p, r_ff.iir_en);
                            default: nxt_r.res[Q_H] = {r_ff.d_sync[RES_W-1 -: HUM_W], 4'h0};
                        endcase
                        nxt_r.ticks = 5'h00;
                        nxt_r.qty = r_ff.qty + 2'h1;
                        nxt_r.conv_active = 1'b0;
                        tph_done = (r_ff.qty == Q_H);
                    end
                end
                if (tph_done) begin
                    nxt_r.qty = Q_G;
                    nxt_r.conv_active = 1'b0;
                    if (!r_ff.gas_en) begin
                        nxt_r.st = ST_STORE; // RULE_16
                    end else begin
                        nxt_r.st = ST_HEAT; // RULE_22
                        if (r_ff.mode == MODE_FORCED) begin
                            // Single-shot heats only after T, P, H are done
                            nxt_r.heater_on = 1'b1; // RULE_08 RULE_07
                            nxt_r.heater_sp = r_ff.res_heat[r_ff.cur_step];
                            nxt_r.ms_left = heat_ms(r_ff.gas_wait[r_ff.cur_step]); // RULE_17
                            nxt_r.pres = 32'h0000_0000;
                            nxt_r.heat_run = (heat_ms(r_ff.gas_wait[r_ff.cur_step]) != 12'h000);
                        end
                    end
                end
            end
            ST_HEAT: begin
                if (!r_ff.heat_run) begin
                    nxt_r.st = ST_GAS;
                    nxt_r.ticks = 5'h00;
                end
            end
            ST_GAS: begin
                nxt_r.conv_sel = Q_G;
                nxt_r.conv_active = 1'b1;
                if (rise) begin
                    nxt_r.ticks = r_ff.ticks + 5'h01;
                    if (r_ff.ticks == GAS_TICKS - 5'h01) begin
                        nxt_r.res[Q_G] = r_ff.d_sync;
                        nxt_r.conv_active = 1'b0;
                        nxt_r.heater_on = 1'b0; // RULE_08
                        nxt_r.st = ST_STORE;
                    end
                end
            end
            ST_STORE: begin
                nxt_r.heater_on = 1'b0;
                nxt_r.fld[r_ff.wr_ptr] = r_ff.res; // RULE_24
                // Smoothing applies to temperature and pressure, never H or gas
                if (r_ff.iir_en) begin // RULE_20
                    nxt_r.filt_t = r_ff.filt_ok ? smooth(r_ff.filt_t, r_ff.res[Q_T]) : r_ff.res[Q_T];
                    nxt_r.filt_p = r_ff.filt_ok ? smooth(r_ff.filt_p, r_ff.res[Q_P]) : r_ff.res[Q_P];
                    nxt_r.filt_ok = 1'b1;
                    nxt_r.fld[r_ff.wr_ptr][Q_T] = nxt_r.filt_t;
                    nxt_r.fld[r_ff.wr_ptr][Q_P] = nxt_r.filt_p;
                end else begin
                    nxt_r.filt_ok = 1'b0;
                end
                // New-data set wins over a read clear in the same cycle
                nxt_r.fld_new[r_ff.wr_ptr] = 1'b1;
                if (r_ff.mode == MODE_PARALLEL) begin
                    nxt_r.wr_ptr = (r_ff.wr_ptr == 2'(FIELDS - 1)) ? 2'h0 : r_ff.wr_ptr + 2'h1; // RULE_19
                    nxt_r.cur_step = (r_ff.cur_step >= sel) ? 4'h0 : r_ff.cur_step + 4'h1; // RULE_11
                end
                if (r_ff.pend) begin
                    nxt_r.mode = r_ff.pend_mode; // RULE_02
                    nxt_r.pend = 1'b0;
                    nxt_r.cur_step = 4'h0;
                    nxt_r.wr_ptr = 2'h0;
                end else if (r_ff.mode == MODE_FORCED) begin
                    nxt_r.mode = MODE_SLEEP; // RULE_05
                end
                // Parallel mode simply re-enters the cycle from idle
                nxt_r.st = ST_IDLE; // RULE_06
            end
            default: begin
                nxt_r.st = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_ff <= '0; // RULE_01
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = r_ff.awrdy;
    assign s_axi_wready = r_ff.wrdy;
    assign s_axi_bvalid = r_ff.bvalid;
    assign s_axi_bresp = r_ff.bresp;
    assign s_axi_arready = r_ff.arrdy;
    assign s_axi_rvalid = r_ff.rvalid;
    assign s_axi_rdata = r_ff.rdata;
    assign s_axi_rresp = r_ff.rresp;
    assign conv_active = r_ff.conv_active;
    assign conv_select = r_ff.conv_sel;
    assign heater_on = r_ff.heater_on;
    assign heater_setpoint = r_ff.heater_sp;

endmodule : egs_sequencer

// >>> egs_front_end.sv
// Converter front end model: free tick and result word.
// Assumes the bench picks the result value.
`timescale 1ns/1ps
module egs_front_end (
    // From bench
    val,
    // To sequencer
    conv_tick,
    conv_data
);
    input wire logic [19:0] val;
    output logic conv_tick = 1'b0;
    output logic [19:0] conv_data;
    // Runs free like the converter oscillator
    always #80 conv_tick = ~conv_tick;
    // Launched on the falling edge so it is stable at the sampled edge
    always @(negedge conv_tick) conv_data <= val;
endmodule : egs_front_end

// >>> egs_sequencer_asserts.sv
// Checker for bus handshakes and sequencer outputs.
// Assumes binding to egs_sequencer; sees its ports only.
`timescale 1ns/1ps
module egs_sequencer_asserts (
    // Clock and reset
    input wire logic aclk, aresetn,
    // Bus
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    // Front end
    input wire logic conv_active, heater_on,
    input wire logic [1:0] conv_select,
    input wire logic [7:0] heater_setpoint
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Output relations; bus ones guard the handshake timing
    rst_quiet_a: assert property ($rose(aresetn) |-> !conv_active && !heater_on)
        else $error("active at reset exit");
    gas_heat_a: assert property (conv_active && conv_select == 2'h3 |-> heater_on)
        else $error("gas phase unheated");
    heat_end_a: assert property ($fell(heater_on) |-> !conv_active)
        else $error("heater off mid conversion");
    step_hold_a: assert property (heater_on && $past(heater_on) |-> $stable(heater_setpoint))
        else $error("setpoint moved");
    sel_order_a: assert property ($changed(conv_select)
        |-> conv_select == $past(conv_select) + 2'h1 || conv_select == 2'h0)
        else $error("conversion order");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
    b_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready early");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read answer");
    r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read repeated");
    cover property (conv_active && conv_select == 2'h3);
    cover property ($fell(heater_on));
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : egs_sequencer_asserts
bind egs_sequencer egs_sequencer_asserts chk_u (.*);

// >>> egs_sequencer_test.sv
// Testbench: host register traffic with result checks.
// Assumes the front end model and the bound checker.
`timescale 1ns/1ps
module egs_sequencer_test import egs_pkg::*;;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, conv_tick, conv_active, heater_on;
    logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, r;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, conv_select, rs;
    logic [7:0] heater_setpoint;
    logic [RES_W-1:0] conv_data, d;
    logic [2:0] os [3];
    int n_errors = 0, checked = 0, q;
    always #10 aclk = ~aclk;
    egs_front_end fe_u (.val(d), .conv_tick(conv_tick), .conv_data(conv_data));
    egs_sequencer #(.MS_CYCLES(5)) dut_u (.*);
    // Compare and report
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task end_of_test;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // Bus cycles, bounded so a hang ends the run
    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        int i;
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        for (i = 0; i < 99; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        rs = s_axi_bresp;
        if (i == 99) begin n_errors++; end_of_test(); end
    endtask : wr
    task rd(input logic [ADDR_W-1:0] a);
        int i;
        s_axi_araddr <= a; s_axi_arvalid <= 1;
        for (i = 0; i < 99; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        r = s_axi_rdata; rs = s_axi_rresp;
        if (i == 99) begin n_errors++; end_of_test(); end
    endtask : rd
    task waitfor(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] v);
        int i;
        for (i = 0; i < 999; i++) begin rd(a); if ((r & m) === v) break; end
        if (i == 999) begin n_errors++; end_of_test(); end
    endtask : waitfor
    // Field word expected from the result, code and quantity
    function logic [31:0] fexp(input int k, input logic [2:0] o);
        if (k == 2) return {12'h0, d & 20'hF_FFF0};
        if (k == 3) return {12'h0, d};
        return {12'h0, d & (20'hF_FFFF << (5 - o))};
    endfunction : fexp
    initial begin
        void'($urandom(32'h1835));
        d = $urandom;
        foreach (os[k]) os[k] = 3'(1 + $urandom % 5);
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(OFS_STATUS); chk(r, 0);
        wr(OFS_MEAS, 32'({os[2], 6'h0}));
        wr(OFS_MEAS, 32'({os[2], os[1], os[0]}));
        wr(OFS_WAIT_BASE, 1);
        wr(OFS_HEAT_BASE, 32'(d[7:0]));
        wr(OFS_GAS, 32'h10);
        wr(OFS_MODE, 1);
        waitfor(OFS_STATUS, 1, 0);
        rd(OFS_MODE); chk(r, 0);
        chk(heater_setpoint, d[7:0]);
        for (q = 0; q < 4; q++) begin
            rd(OFS_FLD_BASE + 12'(4 * q)); chk(r, fexp(q, os[q % 3]));
        end
        wr(OFS_MODE, 1);
        wr(OFS_MODE, 2);
        rd(OFS_STATUS); chk(r[1], 1);
        wr(OFS_GAS, 0);
        rd(OFS_GAS); chk(r, 32'h10);
        waitfor(OFS_MODE, 3, 2);
        repeat (900) @(posedge aclk);
        rd(OFS_MODE); chk(r, 2);
        wr(OFS_MODE, 0);
        waitfor(OFS_STATUS, 3, 0);
        rd(OFS_MODE); chk(r, 0);
        wr(OFS_MODE, 3);
        repeat (20) @(posedge aclk);
        rd(OFS_STATUS); chk(r[0], 0);
        wr(12'hFFC, 5); chk(rs, RESP_SLVERR);
        rd(12'hFFC); chk(rs, RESP_SLVERR);
        end_of_test();
    end
endmodule : egs_sequencer_test
